// ==== verilog/counter_array_pkg.sv ====
// shared constants and types for the counter array and its capture/compare cells
`default_nettype none
package counter_array_pkg;
	localparam int unsigned CNT_W        = 16;        // time base width
	localparam int unsigned NUM_CELLS    = 5;         // capture/compare cells
	localparam int unsigned WDT_CELL     = 4;         // cell that can act as watchdog
	localparam logic [3:0]  DIV12_LAST   = 4'hb;      // system clock / 12
	localparam logic [1:0]  DIV4_LAST    = 2'h3;      // system clock / 4
	localparam logic [2:0]  DIV8_LAST    = 3'h7;      // external oscillator / 8
	localparam logic [3:0]  DIV12_RST    = 4'h0;
	localparam logic [1:0]  DIV4_RST     = 2'h0;
	localparam logic [2:0]  DIV8_RST     = 3'h0;
	localparam logic [15:0] COUNT_RST    = 16'h0000;
	localparam logic        WDT_EN_RST   = 1'b1;      // watchdog alive out of reset
	localparam logic [7:0]  LOW_LAST     = 8'hff;     // low byte about to wrap

	// time base clock sources
	typedef enum logic [2:0] {
		SRC_SYS_DIV12,
		SRC_SYS_DIV4,
		SRC_T0_OVF,
		SRC_EXT_COUNT_INPUT,
		SRC_SYS,
		SRC_EXT_OSC_DIV8
	} clk_src_t;

	// cell operating modes
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_CAPTURE,
		MODE_SW_TIMER,
		MODE_HS_OUTPUT,
		MODE_PWM8,
		MODE_PWM16,
		MODE_FREQ_OUT,
		MODE_WATCHDOG
	} mode_t;
endpackage
`default_nettype wire

// ==== verilog/capture_compare_cell.sv ====
// one capture/compare cell working off the shared time base
`default_nettype none
module capture_compare_cell #(
	parameter bit IS_WDT = 1'b0                          // only one cell may be a watchdog
) (
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_rst,
	input  wire logic                    i_ce,
	input  wire logic                    i_tick,         // time base advances this cycle
	input  wire logic [15:0]             i_count,        // current time base value
	input  wire counter_array_pkg::mode_t i_mode,
	input  wire logic [15:0]             i_cmp,          // compare / period value
	input  wire logic                    i_pin,          // synchronised pin level
	input  wire logic                    i_kick,         // watchdog service pulse
	output logic                         o_pin_out,
	output logic                         o_pin_oe,
	output logic [15:0]                  o_cap_val,
	output logic                         o_event,
	output logic                         o_wdt_reset
);
	// true for modes that drive the pin through the crossbar
	function automatic logic drives_pin(input counter_array_pkg::mode_t m);
		drives_pin = (m == counter_array_pkg::MODE_HS_OUTPUT) ||
			(m == counter_array_pkg::MODE_PWM8) ||
			(m == counter_array_pkg::MODE_PWM16) ||
			(m == counter_array_pkg::MODE_FREQ_OUT);
	endfunction

	counter_array_pkg::mode_t mode;                      // effective mode
	logic        pin_q, pin_d;                           // last pin level, for edges
	logic        out_q, out_d;
	logic [15:0] cap_q, cap_d;
	logic        evt_q, evt_d;
	logic        wdt_q, wdt_d;
	logic [7:0]  ref_q, ref_d;                           // next toggle / watchdog limit
	logic        match16;

	// a watchdog request on an ordinary cell falls back to off
	assign mode    = (i_mode == counter_array_pkg::MODE_WATCHDOG && !IS_WDT) ?
		counter_array_pkg::MODE_OFF : i_mode;
	assign match16 = i_tick && (i_count == i_cmp);

	// next state per mode, one mode at a time
	always_comb begin
		pin_d = i_pin;
		out_d = out_q;
		cap_d = cap_q;
		evt_d = 1'b0;
		wdt_d = 1'b0;
		ref_d = ref_q;
		case (mode)
			counter_array_pkg::MODE_CAPTURE: begin
				if (i_pin && !pin_q) begin                    // rising edge only
					cap_d = i_count;
					evt_d = 1'b1;
				end
			end
			counter_array_pkg::MODE_SW_TIMER: begin
				evt_d = match16;
			end
			counter_array_pkg::MODE_HS_OUTPUT: begin
				if (match16) begin
					out_d = ~out_q;
					evt_d = 1'b1;
				end
			end
			counter_array_pkg::MODE_PWM8: begin
				out_d = (i_count[7:0] >= i_cmp[7:0]);
			end
			counter_array_pkg::MODE_PWM16: begin
				out_d = (i_count >= i_cmp);
			end
			counter_array_pkg::MODE_FREQ_OUT: begin
				// half period is the high byte; wrap of the byte add is intended
				if (i_tick && i_count[7:0] == ref_q) begin
					out_d = ~out_q;
					ref_d = ref_q + i_cmp[15:8];
				end
			end
			counter_array_pkg::MODE_WATCHDOG: begin
				if (i_kick) begin
					ref_d = i_count[15:8] + i_cmp[15:8];
				end else if (i_tick && i_count[15:8] == ref_q &&
						i_count[7:0] == counter_array_pkg::LOW_LAST) begin
					wdt_d = 1'b1;
				end
			end
			default: begin
				out_d = 1'b0;                                 // idle cell parks low
			end
		endcase
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_q <= 1'b0;
			out_q <= 1'b0;
			cap_q <= 16'h0000;
			evt_q <= 1'b0;
			wdt_q <= 1'b0;
			ref_q <= 8'h00;
		end else if (i_ce) begin
			pin_q <= pin_d;
			out_q <= out_d;
			cap_q <= cap_d;
			evt_q <= evt_d;
			wdt_q <= wdt_d;
			ref_q <= ref_d;
		end
	end

	assign o_pin_out   = out_q;
	assign o_pin_oe    = drives_pin(mode);
	assign o_cap_val   = cap_q;
	assign o_event     = evt_q;
	assign o_wdt_reset = wdt_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	capture_takes_count_a: assert property (
		(i_ce && mode == counter_array_pkg::MODE_CAPTURE && i_pin && !pin_q)
		|=> (o_cap_val == $past(i_count) && o_event))
		else $error("capture value does not match time base");
	plain_cell_no_wdt_a: assert property (
		!IS_WDT |-> !o_wdt_reset)
		else $error("watchdog reset from a cell without watchdog");
	oe_output_modes_a: assert property (
		o_pin_oe |-> (mode != counter_array_pkg::MODE_CAPTURE &&
			mode != counter_array_pkg::MODE_OFF))
		else $error("pin driven in a non-output mode");
	cover_capture_c: cover property (
		i_ce && mode == counter_array_pkg::MODE_CAPTURE && i_pin && !pin_q);
	cover_toggle_c: cover property (
		mode == counter_array_pkg::MODE_HS_OUTPUT && $changed(out_q));
endmodule
`default_nettype wire

// ==== verilog/counter_array.sv ====
// counter array: shared 16-bit time base, clock source selection, five cells
// How it works
// - one private 16-bit time base feeds five cells
// - time base clock picked from six sources
// - each cell runs exactly one mode
// - only cell four offers the watchdog
// - watchdog on cell four enabled out of reset
// - cell pins and count input go to crossbar
// - external oscillator may clock the time base
`default_nettype none
module counter_array (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_rst,
	input  wire logic                        i_ce,           // freezes all registers when low
	input  wire counter_array_pkg::clk_src_t i_clk_src,      // time base clock choice
	input  wire logic                        i_run,          // time base run enable
	input  wire logic                        i_t0_ovf,       // timer 0 overflow pulse
	input  wire logic                        i_ext_count_input, // from crossbar pin
	input  wire logic                        i_ext_osc,      // external oscillator level
	input  wire logic [14:0]                 i_cell_mode,    // 3 bits per cell
	input  wire logic [79:0]                 i_cell_cmp,     // 16 bits per cell
	input  wire logic [4:0]                  i_cell_pin,     // capture pins from crossbar
	input  wire logic                        i_wdt_kick,     // watchdog service pulse
	input  wire logic                        i_wdt_disable,  // turn watchdog off
	input  wire logic                        i_wdt_enable,   // turn watchdog back on
	output logic [15:0]                      o_count,
	output logic                             o_overflow,
	output logic [4:0]                       o_cell_out,     // to crossbar
	output logic [4:0]                       o_cell_oe,
	output logic [79:0]                      o_cell_cap,
	output logic [4:0]                       o_cell_event,
	output logic                             o_wdt_reset,
	output logic                             o_wdt_active
);
	logic [3:0]  div12_q, div12_d;
	logic [1:0]  div4_q,  div4_d;
	logic [2:0]  div8_q,  div8_d;
	logic [15:0] cnt_q,   cnt_d;
	logic        ovf_q,   ovf_d;
	logic        wdt_en_q, wdt_en_d;
	logic [1:0]  eci_s_q;                                   // two-stage synchroniser
	logic        eci_d_q;                                   // delayed copy for edges
	logic [1:0]  osc_s_q;
	logic        osc_d_q;
	logic [4:0]  pin_s1_q, pin_s2_q;                         // capture pin synchronisers
	logic        tick12, tick4, eci_rise, osc_rise, osc_tick, tick;
	logic [4:0]  cell_wdt;

	// prescaler ticks are gated by the enable so a frozen block never advances
	assign tick12   = i_ce && (div12_q == counter_array_pkg::DIV12_LAST);
	assign tick4    = i_ce && (div4_q == counter_array_pkg::DIV4_LAST);
	assign eci_rise = i_ce && eci_s_q[1] && !eci_d_q;
	assign osc_rise = i_ce && osc_s_q[1] && !osc_d_q;
	assign osc_tick = osc_rise && (div8_q == counter_array_pkg::DIV8_LAST);

	// source multiplexer
	always_comb begin
		case (i_clk_src)
			counter_array_pkg::SRC_SYS_DIV12:       tick = tick12;
			counter_array_pkg::SRC_SYS_DIV4:        tick = tick4;
			counter_array_pkg::SRC_T0_OVF:          tick = i_ce && i_t0_ovf;
			counter_array_pkg::SRC_EXT_COUNT_INPUT: tick = eci_rise;
			counter_array_pkg::SRC_SYS:             tick = i_ce;
			counter_array_pkg::SRC_EXT_OSC_DIV8:    tick = osc_tick;
			default:                                tick = 1'b0;
		endcase
	end

	// next values of prescalers, time base and watchdog enable
	always_comb begin
		div12_d = tick12 ? counter_array_pkg::DIV12_RST : div12_q + 4'h1;
		div4_d  = div4_q + 2'h1;
		// oscillator divider counts oscillator edges only, not system cycles
		div8_d  = osc_rise ? div8_q + 3'h1 : div8_q;
		cnt_d   = cnt_q;
		ovf_d   = 1'b0;
		// the watchdog needs a running time base, so it keeps it counting
		if (tick && (i_run || wdt_en_q)) begin
			cnt_d = cnt_q + 16'h0001;
			ovf_d = (cnt_q == 16'hffff);
		end
		wdt_en_d = wdt_en_q;
		if (i_wdt_enable) begin
			wdt_en_d = 1'b1;
		end else if (i_wdt_disable) begin
			wdt_en_d = 1'b0;
		end
	end

	// registers; the async inputs pass two flops before anyone looks at them
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			div12_q  <= counter_array_pkg::DIV12_RST;
			div4_q   <= counter_array_pkg::DIV4_RST;
			div8_q   <= counter_array_pkg::DIV8_RST;
			cnt_q    <= counter_array_pkg::COUNT_RST;
			ovf_q    <= 1'b0;
			wdt_en_q <= counter_array_pkg::WDT_EN_RST;
			eci_s_q  <= 2'b00;
			eci_d_q  <= 1'b0;
			osc_s_q  <= 2'b00;
			osc_d_q  <= 1'b0;
			pin_s1_q <= 5'h00;
			pin_s2_q <= 5'h00;
		end else if (i_ce) begin
			div12_q  <= div12_d;
			div4_q   <= div4_d;
			div8_q   <= div8_d;
			cnt_q    <= cnt_d;
			ovf_q    <= ovf_d;
			wdt_en_q <= wdt_en_d;
			eci_s_q  <= {eci_s_q[0], i_ext_count_input};
			eci_d_q  <= eci_s_q[1];
			osc_s_q  <= {osc_s_q[0], i_ext_osc};
			osc_d_q  <= osc_s_q[1];
			pin_s1_q <= i_cell_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	// five cells; cell four is forced into watchdog while that is enabled
	for (genvar g = 0; g < counter_array_pkg::NUM_CELLS; g++) begin : g_cell
		counter_array_pkg::mode_t cell_mode;
		if (g == counter_array_pkg::WDT_CELL) begin : g_wdt
			assign cell_mode = wdt_en_q ? counter_array_pkg::MODE_WATCHDOG :
				counter_array_pkg::mode_t'(i_cell_mode[3*g +: 3]);
		end else begin : g_plain
			assign cell_mode = counter_array_pkg::mode_t'(i_cell_mode[3*g +: 3]);
		end
		capture_compare_cell #(
			.IS_WDT (g == counter_array_pkg::WDT_CELL)
		) u_cell (
			.i_ref_clk   (i_ref_clk),
			.i_rst       (i_rst),
			.i_ce        (i_ce),
			.i_tick      (tick && (i_run || wdt_en_q)),
			.i_count     (cnt_q),
			.i_mode      (cell_mode),
			.i_cmp       (i_cell_cmp[16*g +: 16]),
			.i_pin       (pin_s2_q[g]),
			.i_kick      (i_wdt_kick),
			.o_pin_out   (o_cell_out[g]),
			.o_pin_oe    (o_cell_oe[g]),
			.o_cap_val   (o_cell_cap[16*g +: 16]),
			.o_event     (o_cell_event[g]),
			.o_wdt_reset (cell_wdt[g])
		);
	end

	assign o_count      = cnt_q;
	assign o_overflow   = ovf_q;
	assign o_wdt_reset  = cell_wdt[counter_array_pkg::WDT_CELL];
	assign o_wdt_active = wdt_en_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	count_step_a: assert property (
		(tick && (i_run || wdt_en_q)) |=> (cnt_q == $past(cnt_q) + 16'h0001))
		else $error("time base did not step by one");
	count_hold_a: assert property (
		!(tick && (i_run || wdt_en_q)) |=> $stable(cnt_q))
		else $error("time base moved without a tick");
	div12_spacing_a: assert property (
		tick12 |=> !tick12 [*8])
		else $error("divide by 12 tick too early");
	div4_spacing_a: assert property (
		tick4 |=> !tick4 [*3])
		else $error("divide by 4 tick too early");
	osc_div8_a: assert property (
		osc_tick |=> !osc_tick [*7])
		else $error("oscillator divide by 8 tick too early");
	eci_single_a: assert property (
		(i_clk_src == counter_array_pkg::SRC_EXT_COUNT_INPUT && tick) |=> !tick)
		else $error("one input edge counted twice");
	eci_latency_a: assert property (
		(i_ce [*4] ##0 $rose(eci_s_q[1]) && i_clk_src ==
			counter_array_pkg::SRC_EXT_COUNT_INPUT && (i_run || wdt_en_q))
		|=> (cnt_q == $past(cnt_q) + 16'h0001))
		else $error("input edge did not advance time base");
	wdt_after_reset_a: assert property (
		$past(i_rst) |-> (wdt_en_q && o_wdt_active))
		else $error("watchdog not enabled after reset");
	wdt_only_cell4_a: assert property (
		(cell_wdt[3:0] == 4'h0))
		else $error("watchdog reset from wrong cell");
	cover_overflow_c: cover property (o_overflow);
	cover_wdt_fire_c: cover property (o_wdt_reset);
	cover_eci_count_c: cover property (
		i_clk_src == counter_array_pkg::SRC_EXT_COUNT_INPUT && tick);
endmodule
`default_nettype wire

// ==== testbench/crossbar_pins_model.sv ====
// pin-side model: count input pulses, oscillator bursts, capture pin edges
`default_nettype none
module crossbar_pins_model (
	input  wire logic i_ref_clk,
	output logic      o_ext_count_input,
	output logic      o_ext_osc,
	output logic [4:0] o_cell_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// lines rest low; the oscillator halts between bursts
	initial begin
		o_ext_count_input = 1'b0;
		o_ext_osc         = 1'b0;
		o_cell_pin        = 5'h00;
	end
	// let n edges pass, then settle just after the last
	task automatic hold(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// n count pulses, 4 high and 4 low so the synchroniser sees each one
	task automatic count_pulses(input int n);
		repeat (n) begin
			o_ext_count_input = 1'b1;
			hold(4);
			o_ext_count_input = 1'b0;
			hold(4);
		end
	endtask
	// n oscillator periods of 3 high 3 low, slower than the sync path
	task automatic osc_cycles(input int n);
		repeat (n) begin
			o_ext_osc = 1'b1;
			hold(3);
			o_ext_osc = 1'b0;
			hold(3);
		end
	endtask
	// one rising edge on the capture pin of cell g
	task automatic pin_edge(input int g);
		o_cell_pin[g] = 1'b1;
		hold(4);
		o_cell_pin[g] = 1'b0;
		hold(4);
	endtask
endmodule
`default_nettype wire

// ==== testbench/counter_array_bench.sv ====
// self-checking bench for the counter array
`default_nettype none
module counter_array_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {int g; logic [15:0] cap; bit chk;} note_t; // expected cell event
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, run = 1'b0, t0 = 1'b0;
	logic kick = 1'b0, wdis = 1'b0, wen = 1'b0;
	counter_array_pkg::clk_src_t src = counter_array_pkg::SRC_SYS;
	logic [14:0] mode = 15'h0000;  // three bits per cell
	logic [79:0] cmp  = 80'h0;     // sixteen bits per cell
	wire logic ext_count_input, osc;
	wire logic [4:0] pin;
	logic [15:0] count, c0, cnt;   // cnt is the expected time base
	logic [79:0] cap;
	logic [4:0] out, oe, ev, e;
	logic ovf, wrst, wact;
	int errors = 0, comparisons = 0, n;
	note_t evq[$], nt;             // pending cell events
	logic [15:0] wq[$];            // expected count at each watchdog expiry
	counter_array_pkg::clk_src_t srcs[3] = '{counter_array_pkg::SRC_SYS_DIV12,
		counter_array_pkg::SRC_SYS_DIV4, counter_array_pkg::SRC_SYS};
	int per[3] = '{12, 4, 1};

	always #25 clk = ~clk; // 20 MHz

	counter_array dut (.i_ref_clk(clk), .i_rst(rst), .i_ce(ce), .i_clk_src(src), .i_run(run),
		.i_t0_ovf(t0), .i_ext_count_input(ext_count_input), .i_ext_osc(osc), .i_cell_mode(mode),
		.i_cell_cmp(cmp), .i_cell_pin(pin), .i_wdt_kick(kick), .i_wdt_disable(wdis),
		.i_wdt_enable(wen), .o_count(count), .o_overflow(ovf), .o_cell_out(out),
		.o_cell_oe(oe), .o_cell_cap(cap), .o_cell_event(ev), .o_wdt_reset(wrst),
		.o_wdt_active(wact));
	crossbar_pins_model xb (.i_ref_clk(clk), .o_ext_count_input(ext_count_input), .o_ext_osc(osc),
		.o_cell_pin(pin));

	// every drive lands 1 ns after a rising edge
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// bounded wait for all expected results to show up
	task automatic drain(input int lim);
		for (int i = 0; i < lim && evq.size() + wq.size() > 0; i++) step(1);
		if (evq.size() + wq.size() != 0) begin
			errors++;
			$display("ERROR pending results expected 0 seen %0d", evq.size() + wq.size());
			results();
		end
	endtask
	task automatic do_reset(input counter_array_pkg::clk_src_t s);
		rst = 1'b1;
		src = s;
		step(2);
		rst = 1'b0;
		cnt = 16'h0000;
	endtask

	// monitor: oldest note against each result as it appears
	always @(negedge clk) begin
		if (!rst && |ev) begin
			if (evq.size() == 0) chk("cell event", 16'h0000, {11'h000, ev});
			else begin
				nt = evq.pop_front();
				chk("cell event", 16'(5'h01 << nt.g), {11'h000, ev});
				if (nt.chk) chk("capture", nt.cap, cap[16*nt.g+:16]);
			end
		end
		if (!rst && wrst) begin
			if (wq.size() == 0) chk("watchdog reset", 16'h0000, 16'h0001);
			else chk("watchdog count", wq.pop_front(), count);
		end
	end

	// a hang counts against the run
	initial begin
		#2000000;
		errors++;
		$display("ERROR run length expected end seen timeout");
		results();
	end

	initial begin
		void'($urandom(2));
		// watchdog alive out of reset, cell four held off the pins
		mode = {5{3'h5}};
		do_reset(counter_array_pkg::SRC_SYS);
		chk("drive enable", 16'h000f, {11'h000, oe});
		chk("watchdog on", 16'h0001, {15'h0000, wact});
		wq.push_back(16'h0100);
		drain(400);
		// service pulse moves the limit two pages on
		do_reset(counter_array_pkg::SRC_SYS);
		cmp[79:64] = 16'h0200;
		step(1);
		kick = 1'b1;
		step(1);
		kick = 1'b0;
		wq.push_back(16'h0300);
		drain(900);
		// quiet start: no ticks, watchdog off
		do_reset(counter_array_pkg::clk_src_t'(3'h6));
		wdis = 1'b1;
		step(1);
		wdis = 1'b0;
		// every mode: pin drive only in output modes, mode 7 off on cells 0-3
		for (int m = 0; m < 8; m++) begin
			mode = {5{m[2:0]}};
			step(1);
			chk("drive enable", (m >= 3 && m <= 6) ? 16'h000f : 16'h0000,
				{12'h000, oe[3:0]});
		end
		// timer 0 overflow pulses, one count each
		src = counter_array_pkg::SRC_T0_OVF;
		run = 1'b1;
		n = $urandom_range(40, 1);
		repeat (n) begin
			t0 = 1'b1;
			step(1);
			t0 = 1'b0;
			step(1);
		end
		step(2);
		cnt = cnt + 16'(n);
		chk("count t0", cnt, count);
		// pwm levels on a still time base
		for (int g = 0; g < 5; g++) cmp[16*g+:16] = {8'($urandom), 8'($urandom_range(80, 0))};
		for (int k = 4; k < 6; k++) begin
			mode = {5{k[2:0]}};
			step(3);
			for (int g = 0; g < 5; g++)
				e[g] = (k == 5) ? (cnt >= cmp[16*g+:16]) : (cnt[7:0] >= cmp[16*g+:8]);
			chk("pwm level", {11'h000, e}, {11'h000, out});
		end
		// capture edge on each cell pin
		mode = {5{3'h1}};
		step(2);
		for (int g = 0; g < 5; g++) begin
			evq.push_back('{g, cnt, 1'b1});
			xb.pin_edge(g);
		end
		drain(20);
		// software timer then high speed output, staggered matches
		for (int k = 2; k < 4; k++) begin
			mode = 15'h0000;
			step(2);
			for (int g = 0; g < 5; g++) begin
				cmp[16*g+:16] = cnt + 16'(10 * (g + 1));
				evq.push_back('{g, 16'h0000, 1'b0});
			end
			mode = {5{k[2:0]}};
			src = counter_array_pkg::SRC_SYS;
			run = 1'b1;
			step(60);
			run = 1'b0;
			cnt = cnt + 16'd60;
			drain(5);
			chk("count sys", cnt, count);
			if (k == 3) chk("toggled out", 16'h001f, {11'h000, out});
		end
		// external count input pulses
		src = counter_array_pkg::SRC_EXT_COUNT_INPUT;
		run = 1'b1;
		n = $urandom_range(10, 1);
		xb.count_pulses(n);
		step(4);
		cnt = cnt + 16'(n);
		chk("count ext input", cnt, count);
		// external oscillator divided by eight
		src = counter_array_pkg::SRC_EXT_OSC_DIV8;
		n = $urandom_range(4, 1);
		xb.osc_cycles(8 * n);
		step(4);
		cnt = cnt + 16'(n);
		chk("count ext osc", cnt, count);
		// system clock rates, /12, /4 and undivided, over a whole number of periods
		for (int s = 0; s < 3; s++) begin
			src = srcs[s];
			step(3);
			c0 = count;
			step(48);
			chk("count rate", 16'(48 / per[s]), count - c0);
		end
		// clock enable low freezes the time base
		ce = 1'b0;
		c0 = count;
		step(10);
		chk("frozen count", c0, count);
		ce = 1'b1;
		results();
	end
endmodule
`default_nettype wire
